// ### hw/sms_pkg.sv
// Package of constants for the serial master/slave port.
// Functional notes
// - Transfer is 8 or 16 shift pulses
// - Completion sets flag, enable gates request
// - Completed word copied to receive holding buffer
// - Full holding buffer: overflow, word dropped
// - Overflow set: slave-mode clock edges are ignored
// - Transfer end: store rx, load pending tx
// - One data address: write tx, read rx
// - Master starts transfer on data write
// - Clock pin output as master, input as slave
// - Slave select is active low
// - Master clock is primary times secondary division; the code rounds odd products down to even, minimum two
// - Enable bit hands pins to port
// - Idle-stop halts module in idle
// - Overflow flag readable, cleared by software
// - Transmit full set on write, cleared on load
// - Receive full set on store, cleared on read
// - Separate error interrupt for overflow
// - Sixteen-bit shift register plus buffer
// - Width select: sixteen when set, else eight
// - Clock idle-high selects polarity
// - Output edge select chooses change edge
// - Sample phase (master only): end or middle of bit
package sms_pkg;
  localparam logic [3:0] SMS_ADDR_STAT = 4'h0;
  localparam logic [3:0] SMS_ADDR_CON1 = 4'h2;
  localparam logic [3:0] SMS_ADDR_CON2 = 4'h4;
  localparam logic [3:0] SMS_ADDR_BUF = 4'h8;
  localparam logic [3:0] SMS_ADDR_IRQ = 4'hA;
  localparam int SMS_STAT_EN = 15;
  localparam int SMS_STAT_SIDL = 13;
  localparam int SMS_STAT_ROV = 6;
  localparam int SMS_STAT_TBF = 1;
  localparam int SMS_STAT_RBF = 0;
  localparam int SMS_CON1_W16 = 10;
  localparam int SMS_CON1_SMP = 9;
  localparam int SMS_CON1_CKE = 8;
  localparam int SMS_CON1_SELECT_PIN_ENABLE = 7;
  localparam int SMS_CON1_CKP = 6;
  localparam int SMS_CON1_MST = 5;
  localparam int SMS_CON1_SPRE = 2;
  localparam int SMS_CON1_PPRE = 0;
  localparam int SMS_IRQ_FLAG = 0;
  localparam int SMS_IRQ_EN = 1;
  localparam logic [15:0] SMS_CON1_MASK = 16'h07FF;
  localparam logic [15:0] SMS_STAT_RST = 16'h0000;
  localparam logic [15:0] SMS_CON1_RST = 16'h0000;
  localparam logic [15:0] SMS_CON2_MASK = 16'hE002;
  localparam logic [4:0] SMS_BITS_BYTE = 5'h08;
  localparam logic [4:0] SMS_BITS_WORD = 5'h10;
  typedef enum logic [1:0] {SMS_IDLE = 2'b00, SMS_LEAD = 2'b01, SMS_TRAIL = 2'b11} sms_state_e;
endpackage : sms_pkg

// ### hw/sms_sync.sv
// Two-stage synchroniser for the serial pins.
module sms_sync
  import sms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic d,
  output logic q
);
  logic meta_q;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sms_sync

// ### hw/sms_prescale.sv
// Two-stage prescaler giving the master half-bit tick.
module sms_prescale
  import sms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  input wire logic [1:0] ppre,
  input wire logic [2:0] spre,
  output logic tick
);
  logic [8:0] cnt_q;
  logic [8:0] half_d;
  logic [6:0] prim;
  logic [3:0] sec;

  // Full period is primary times secondary, rounded down to even with a floor of two cycles; the tick marks each half period.
  always_comb
  begin
    unique case (ppre)
      2'b11: prim = 7'd1;
      2'b10: prim = 7'd4;
      2'b01: prim = 7'd16;
      default: prim = 7'd64;
    endcase
    sec = 4'd8 - {1'b0, spre};
    // The slowest setting needs a half period of 256 cycles, hence nine bits.
    half_d = 9'((14'(prim) * 14'(sec)) >> 1);
    if (half_d == 9'd0)
      half_d = 9'd1;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= 9'd0;
    else if (ce)
    begin
      if (!run || tick)
        cnt_q <= 9'd0;
      else
        cnt_q <= cnt_q + 9'd1;
    end
  end

  assign tick = run && (cnt_q == half_d - 9'd1);
endmodule : sms_prescale

// ### hw/sms_port.sv
// Serial master/slave port with register access, shifter and buffers.
module sms_port
  import sms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic idle_mode,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic shift_clock_pin_i,
  output logic shift_clock_pin_o,
  output logic shift_clock_pin_oe_n,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_pin_oe_n,
  input wire logic slave_select_pin_n,
  output logic transfer_irq,
  output logic error_irq
);
  logic module_enable_q;
  logic idle_stop_q;
  logic receive_overflow_q;
  logic tx_buffer_full_q;
  logic rx_buffer_full_q;
  logic transfer_irq_flag_q;
  logic transfer_irq_enable_q;
  logic [15:0] control_one_q;
  logic [15:0] control_two_q;
  logic [15:0] transmit_holding_buffer_q;
  logic [15:0] receive_holding_buffer_q;
  logic [15:0] shift_register_q;
  logic [4:0] bit_cnt_q;
  logic sck_q;
  logic sdo_q;
  logic sck_prev_q;
  sms_state_e state_q;
  logic sck_s;
  logic sdi_s;
  logic ss_s;
  logic run;
  logic master;
  logic cke;
  logic clock_idle_high;
  logic input_sample_phase;
  logic [4:0] nbits;
  logic tick;
  logic done;
  logic data_wr;
  logic data_rd;
  logic lead_edge;
  logic trail_edge;
  logic slave_sel;
  logic shift_edge;
  logic sample_edge;
  logic [15:0] shifted;
  logic next_out;

  sms_sync u_sync_sck (.clk_sys(clk_sys), .nrst(nrst), .d(shift_clock_pin_i), .q(sck_s));
  sms_sync u_sync_sdi (.clk_sys(clk_sys), .nrst(nrst), .d(serial_in_pin), .q(sdi_s));
  sms_sync u_sync_ss (.clk_sys(clk_sys), .nrst(nrst), .d(slave_select_pin_n), .q(ss_s));

  assign master = control_one_q[SMS_CON1_MST];
  assign cke = control_one_q[SMS_CON1_CKE];
  assign clock_idle_high = control_one_q[SMS_CON1_CKP];
  assign input_sample_phase = control_one_q[SMS_CON1_SMP];
  assign nbits = control_one_q[SMS_CON1_W16] ? SMS_BITS_WORD : SMS_BITS_BYTE;
  // The port runs only when enabled and not stopped by idle mode.
  assign run = ce && module_enable_q && !(idle_stop_q && idle_mode);
  assign data_wr = wr && (addr == SMS_ADDR_BUF);
  assign data_rd = rd && (addr == SMS_ADDR_BUF);
  assign slave_sel = !control_one_q[SMS_CON1_SELECT_PIN_ENABLE] || !ss_s;

  sms_prescale u_pre (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .run(run && master && (state_q != SMS_IDLE)),
    .ppre(control_one_q[1:0]),
    .spre(control_one_q[4:2]),
    .tick(tick)
  );

  // Leading edge leaves idle level, trailing edge returns to it.
  always_comb
  begin
    if (master)
    begin
      lead_edge = tick && (state_q == SMS_LEAD);
      trail_edge = tick && (state_q == SMS_TRAIL);
    end
    else
    begin
      lead_edge = (sck_s != sck_prev_q) && ((sck_s ^ clock_idle_high) == 1'b1);
      trail_edge = (sck_s != sck_prev_q) && ((sck_s ^ clock_idle_high) == 1'b0);
      lead_edge = lead_edge && slave_sel && !receive_overflow_q && state_q != SMS_IDLE;
      trail_edge = trail_edge && slave_sel && !receive_overflow_q && state_q != SMS_IDLE;
    end
  end

  // Output changes on trailing edge when CKE set, else on leading edge.
  assign shift_edge = cke ? trail_edge : lead_edge;
  // In master mode end-of-bit sampling moves to the shift edge.
  assign sample_edge = (master && input_sample_phase) ? shift_edge : (cke ? lead_edge : trail_edge);
  // Each sample shifts the received bit in at the bottom of the register.
  assign shifted = {shift_register_q[14:0], sdi_s};
  // When sampling and shifting meet, the next output bit sits one below the top.
  assign next_out = sample_edge
                    ? (control_one_q[SMS_CON1_W16] ? shift_register_q[14] : shift_register_q[6])
                    : (control_one_q[SMS_CON1_W16] ? shift_register_q[15] : shift_register_q[7]);
  // The transfer ends with the last sample, so the last received bit is kept.
  assign done = sample_edge && (bit_cnt_q == nbits - 5'd1);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      sck_prev_q <= 1'b0;
    else if (ce)
      sck_prev_q <= sck_s;
  end

  // Transfer sequencing and the shifter.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= SMS_IDLE;
      shift_register_q <= 16'h0000;
      bit_cnt_q <= 5'h00;
      sdo_q <= 1'b0;
      sck_q <= 1'b0;
    end
    else if (!run)
    begin
      state_q <= SMS_IDLE;
      bit_cnt_q <= 5'h00;
      sck_q <= clock_idle_high;
    end
    else
    begin
      unique case (state_q)
        SMS_IDLE:
        begin
          sck_q <= clock_idle_high;
          if (tx_buffer_full_q)
          begin
            // Loading the word; the first bit goes out at the load, before the first clock edge.
            shift_register_q <= transmit_holding_buffer_q;
            sdo_q <= control_one_q[SMS_CON1_W16] ? transmit_holding_buffer_q[15]
                                                   : transmit_holding_buffer_q[7];
            bit_cnt_q <= 5'h00;
            state_q <= SMS_LEAD;
          end
        end
        SMS_LEAD, SMS_TRAIL:
        begin
          if (lead_edge || trail_edge)
          begin
            if (master)
              sck_q <= lead_edge ? !clock_idle_high : clock_idle_high;
            state_q <= lead_edge ? SMS_TRAIL : SMS_LEAD;
          end
          if (sample_edge)
          begin
            shift_register_q <= shifted;
            bit_cnt_q <= bit_cnt_q + 5'h01;
          end
          // With the edge select clear the first bit already stands from the load.
          if (shift_edge && (cke || bit_cnt_q != 5'h00))
            sdo_q <= next_out;
          if (done)
          begin
            state_q <= SMS_IDLE;
            bit_cnt_q <= 5'h00;
          end
        end
        default:
          state_q <= SMS_IDLE;
      endcase
    end
  end

  // Register writes and buffer/status flags; hardware sets win over clears.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      module_enable_q <= 1'b0;
      idle_stop_q <= 1'b0;
      receive_overflow_q <= 1'b0;
      tx_buffer_full_q <= 1'b0;
      rx_buffer_full_q <= 1'b0;
      transfer_irq_flag_q <= 1'b0;
      transfer_irq_enable_q <= 1'b0;
      control_one_q <= SMS_CON1_RST;
      control_two_q <= SMS_STAT_RST;
      transmit_holding_buffer_q <= 16'h0000;
      receive_holding_buffer_q <= 16'h0000;
    end
    else if (ce)
    begin
      if (wr && addr == SMS_ADDR_STAT)
      begin
        module_enable_q <= wdata[SMS_STAT_EN];
        idle_stop_q <= wdata[SMS_STAT_SIDL];
        if (!wdata[SMS_STAT_ROV])
          receive_overflow_q <= 1'b0;
      end
      if (wr && addr == SMS_ADDR_CON1)
        control_one_q <= wdata & SMS_CON1_MASK;
      if (wr && addr == SMS_ADDR_CON2)
        control_two_q <= wdata & SMS_CON2_MASK;
      if (wr && addr == SMS_ADDR_IRQ)
      begin
        transfer_irq_enable_q <= wdata[SMS_IRQ_EN];
        if (!wdata[SMS_IRQ_FLAG])
          transfer_irq_flag_q <= 1'b0;
      end
      if (data_wr)
      begin
        transmit_holding_buffer_q <= wdata;
        tx_buffer_full_q <= 1'b1;
      end
      else if (run && state_q == SMS_IDLE && tx_buffer_full_q)
        tx_buffer_full_q <= 1'b0;
      if (data_rd)
        rx_buffer_full_q <= 1'b0;
      if (data_rd)
        receive_overflow_q <= receive_overflow_q;
      if (run && done)
      begin
        transfer_irq_flag_q <= 1'b1;
        if (rx_buffer_full_q && !data_rd)
          receive_overflow_q <= 1'b1;
        else
        begin
          // Byte mode keeps the word in the low bits.
          receive_holding_buffer_q <= control_one_q[SMS_CON1_W16] ? shifted
                                      : {8'h00, shifted[7:0]};
          rx_buffer_full_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rdata <= 16'h0000;
    else if (ce && rd)
    begin
      unique case (addr)
        SMS_ADDR_STAT: rdata <= {module_enable_q, 1'b0, idle_stop_q, 6'h00,
                                 receive_overflow_q, 4'h0, tx_buffer_full_q, rx_buffer_full_q};
        SMS_ADDR_CON1: rdata <= control_one_q;
        SMS_ADDR_CON2: rdata <= control_two_q;
        SMS_ADDR_BUF: rdata <= receive_holding_buffer_q;
        SMS_ADDR_IRQ: rdata <= {14'h0000, transfer_irq_enable_q, transfer_irq_flag_q};
        default: rdata <= 16'h0000;
      endcase
    end
  end

  assign transfer_irq = transfer_irq_flag_q && transfer_irq_enable_q;
  assign error_irq = receive_overflow_q;
  assign shift_clock_pin_o = master ? sck_q : clock_idle_high;
  assign shift_clock_pin_oe_n = !(module_enable_q && master);
  assign serial_out_pin = sdo_q;
  assign serial_out_pin_oe_n = !(module_enable_q && (master || slave_sel));

  a_done_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && run && done) |=> transfer_irq_flag_q) else $error("no flag after transfer");
  a_ovf_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && run && done && rx_buffer_full_q && !data_rd) |=> $stable(receive_holding_buffer_q))
    else $error("overflow overwrote buffer");
  a_tbf_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && data_wr) |=> tx_buffer_full_q) else $error("tx full not set");
  a_rbf_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && data_rd && !(run && done)) |=> !rx_buffer_full_q) else $error("rx full kept");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    !transfer_irq_enable_q |-> !transfer_irq) else $error("irq not gated");
  a_clk_dir: assert property (@(posedge clk_sys) disable iff (!nrst)
    (module_enable_q && !master) |-> shift_clock_pin_oe_n) else $error("slave drives clock");
  a_ovf_stall: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!master && receive_overflow_q) |-> !(lead_edge || trail_edge))
    else $error("edge taken in overflow");
  a_bit_count: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_q != SMS_IDLE |-> bit_cnt_q <= SMS_BITS_WORD) else $error("bit count overrun");
  a_ss_release: assert property (@(posedge clk_sys) disable iff (!nrst)
    (module_enable_q && !master && control_one_q[SMS_CON1_SELECT_PIN_ENABLE] && ss_s)
    |-> serial_out_pin_oe_n) else $error("deselected slave drives");
endmodule : sms_port

// ### verif/sms_far_slave.sv
// Behavioural far-side slave device for the serial port bench.
module sms_far_slave
(
  input wire logic sck,
  input wire logic mosi,
  input wire logic load,
  input wire logic w16,
  input wire logic [15:0] tx_word,
  output logic miso,
  output logic [15:0] rx_word,
  output int edges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh;
  initial rx_word = 16'h0000;
  initial edges = 0;
  // The first bit stands before the first clock edge, as with the edge select set.
  assign miso = w16 ? sh[15] : sh[7];
  always @(posedge sck)
  begin
    rx_word <= {rx_word[14:0], mosi};
    edges <= edges + 1;
  end
  always @(negedge sck or posedge load)
  begin
    if (load)
      sh <= tx_word;
    else
      sh <= sh << 1;
  end
endmodule : sms_far_slave

// ### verif/sms_port_bench.sv
// Self-checking bench for the serial master/slave port.
module sms_port_bench;
  import sms_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, nrst, idle_mode, wr, rd, p_load, p_w16, sck_d, b_sck, ss_n;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, p_word, p_rx, v;
  logic sck_o, sck_oe_n, sdo, sdo_oe_n, miso, t_irq, e_irq;
  wire logic sck = sck_oe_n ? b_sck : sck_o;
  wire logic mosi = sdo_oe_n ? 1'b0 : sdo;
  int num_errors, n_compared, edges, cyc, last, per, e0;
  sms_port u_sms_port (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .idle_mode(idle_mode),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .shift_clock_pin_i(sck),
    .shift_clock_pin_o(sck_o), .shift_clock_pin_oe_n(sck_oe_n), .serial_in_pin(miso),
    .serial_out_pin(sdo), .serial_out_pin_oe_n(sdo_oe_n), .slave_select_pin_n(ss_n),
    .transfer_irq(t_irq), .error_irq(e_irq));
  sms_far_slave u_sms_far_slave (.sck(sck), .mosi(mosi), .load(p_load), .w16(p_w16),
    .tx_word(p_word), .miso(miso), .rx_word(p_rx), .edges(edges));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Cycle count, clock period measurement and hang guard.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    sck_d <= sck;
    if (sck && !sck_d)
    begin
      per <= cyc - last;
      last <= cyc;
    end
    if (cyc > 20000)
    begin
      num_errors++;
      finish_test();
    end
  end
  task finish_test();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task bw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask : bw
  task br(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : br
  task send(input logic [15:0] d, input logic [15:0] p);
    @(posedge clk_sys);
    p_word <= p;
    p_load <= 1'b1;
    @(posedge clk_sys);
    p_load <= 1'b0;
    e0 = edges;
    bw(SMS_ADDR_BUF, d);
  endtask : send
  task poll(input int b);
    int n;
    n = 0;
    do
    begin
      br(SMS_ADDR_STAT, v);
      n++;
    end
    while (v[b] !== 1'b1 && n < 200);
  endtask : poll
  initial
  begin
    cyc = 0;
    last = 0;
    per = 0;
    num_errors = 0;
    n_compared = 0;
    {nrst, idle_mode, wr, rd, p_load, p_w16, sck_d} = 7'h00;
    b_sck = 1'b0;
    ss_n = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    p_word = 16'h0000;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    chk("clk_oe_n", 16'h0001, {15'h0000, sck_oe_n});
    br(SMS_ADDR_STAT, v);
    chk("stat_rst", SMS_STAT_RST, v);
    br(SMS_ADDR_CON1, v);
    chk("con1_rst", SMS_CON1_RST, v);
    br(4'hE, v);
    chk("unmapped", 16'h0000, v);
    bw(SMS_ADDR_CON1, 16'hFFFF);
    br(SMS_ADDR_CON1, v);
    chk("con1_mask", SMS_CON1_MASK, v);
    $display("test registers done");
    // Controls first, then overflow clear with enable, data last.
    bw(SMS_ADDR_CON1, 16'h0123);
    bw(SMS_ADDR_IRQ, 16'h0002);
    bw(SMS_ADDR_STAT, 16'h8000);
    chk("clk_oe_n", 16'h0000, {15'h0000, sck_oe_n});
    send(16'h00A5, 16'h003C);
    poll(SMS_STAT_RBF);
    chk("stat_done", 16'h8001, v);
    chk("far_rx8", 16'h00A5, {8'h00, p_rx[7:0]});
    chk("edges8", 16'h0008, 16'(edges - e0));
    chk("sck_per", 16'h0008, 16'(per));
    chk("t_irq", 16'h0001, {15'h0000, t_irq});
    br(SMS_ADDR_BUF, v);
    chk("buf8", 16'h003C, v);
    br(SMS_ADDR_STAT, v);
    chk("stat_read", 16'h8000, v);
    bw(SMS_ADDR_IRQ, 16'h0001);
    chk("t_irq_mask", 16'h0000, {15'h0000, t_irq});
    br(SMS_ADDR_IRQ, v);
    chk("irq_reg", 16'h0001, v);
    bw(SMS_ADDR_IRQ, 16'h0000);
    bw(SMS_ADDR_IRQ, 16'h0002);
    chk("t_irq_clr", 16'h0000, {15'h0000, t_irq});
    $display("test byte transfer done");
    bw(SMS_ADDR_CON1, 16'h0523);
    p_w16 <= 1'b1;
    send(16'h1234, 16'hBEEF);
    poll(SMS_STAT_RBF);
    chk("far_rx16", 16'h1234, p_rx);
    chk("edges16", 16'h0010, 16'(edges - e0));
    br(SMS_ADDR_BUF, v);
    chk("buf16", 16'hBEEF, v);
    $display("test word transfer done");
    send(16'h5A5A, 16'h0F0F);
    poll(SMS_STAT_RBF);
    send(16'hAAAA, 16'h3333);
    poll(SMS_STAT_ROV);
    chk("stat_ovf", 16'h8041, v);
    chk("e_irq", 16'h0001, {15'h0000, e_irq});
    br(SMS_ADDR_BUF, v);
    chk("buf_kept", 16'h0F0F, v);
    br(SMS_ADDR_STAT, v);
    chk("ovf_stays", 16'h8040, v);
    bw(SMS_ADDR_STAT, 16'h8000);
    br(SMS_ADDR_STAT, v);
    chk("ovf_clr", 16'h8000, v);
    chk("e_irq_clr", 16'h0000, {15'h0000, e_irq});
    $display("test overflow done");
    bw(SMS_ADDR_STAT, 16'hA000);
    idle_mode <= 1'b1;
    send(16'hC3C3, 16'h5A5A);
    repeat (40) @(posedge clk_sys);
    chk("idle_edges", 16'h0000, 16'(edges - e0));
    br(SMS_ADDR_STAT, v);
    chk("stat_idle", 16'hA002, v);
    idle_mode <= 1'b0;
    poll(SMS_STAT_RBF);
    br(SMS_ADDR_BUF, v);
    chk("buf_idle", 16'h5A5A, v);
    chk("far_idle", 16'hC3C3, p_rx);
    $display("test idle stop done");
    bw(SMS_ADDR_STAT, 16'h0000);
    chk("oe_off", 16'h0003, {14'h0000, sck_oe_n, sdo_oe_n});
    $display("test disable done");
    // Slave mode: the bench drives the link clock and the select pin.
    bw(SMS_ADDR_CON1, 16'h0180);
    bw(SMS_ADDR_STAT, 16'h8000);
    p_w16 <= 1'b0;
    send(16'h0096, 16'h0069);
    chk("slv_clk_oe_n", 16'h0001, {15'h0000, sck_oe_n});
    chk("slv_sdo_off", 16'h0001, {15'h0000, sdo_oe_n});
    ss_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    repeat (8)
    begin
      repeat (4) @(posedge clk_sys);
      b_sck <= 1'b1;
      repeat (4) @(posedge clk_sys);
      b_sck <= 1'b0;
    end
    chk("slv_sdo_on", 16'h0000, {15'h0000, sdo_oe_n});
    repeat (4) @(posedge clk_sys);
    ss_n <= 1'b1;
    poll(SMS_STAT_RBF);
    chk("slv_stat", 16'h8001, v);
    chk("slv_far_rx", 16'h0096, {8'h00, p_rx[7:0]});
    chk("slv_edges", 16'h0008, 16'(edges - e0));
    br(SMS_ADDR_BUF, v);
    chk("slv_buf", 16'h0069, v);
    chk("slv_sdo_rel", 16'h0001, {15'h0000, sdo_oe_n});
    $display("test slave transfer done");
    finish_test();
  end
endmodule : sms_port_bench
